// ---- src/mmd_pkg.sv ----
/*
  Constants shared by the motor drive controller: servo timebase, frame,
  stepper coil patterns and DC motor PWM figures.
  Assumes one system clock at 250 MHz (4 ns period).
*/
// Notes on behaviour
// - Servo timebase ticks every 50 us; servo pulse widths are whole ticks.
// - Count ticks so each servo pulse repeats once per 20 ms frame.
// - Neutral position gives 1.5 ms pulse; each step adds or removes one tick.
// - Positive step means clockwise and wider pulse; negative means narrower.
// - Servo position step is limited to plus or minus 11.
// - Each servo output rises at frame start, falls when ticks reach its length.
// - Shared pins go to SPI only while servo low with enough time left.
// - SPI select and clock stay direct; a transfer may stall and resume.
// - Each stepper advances once per period timer expiry; period sets speed.
// - On advance bump index, clear coils with mask, then set ON pattern.
// - Step command 0 stops, 1 single steps, 2 to 100 run continuously.
// - Command 0 or 1 stops the timer; above 1 loads period and starts.
// - Direction selects clockwise or counterclockwise pattern for later steps.
// - Step type selects full-step or half-step pattern for later steps.
// - Each timer expiry gives exactly one pattern update.
// - DC motor one uses PWM channel one, motor two channel two, high and low.
// - DC speed is the PWM duty of the enabled output.
// - Direction change while running stops, updates direction, then restarts.
// - Writing speed to a stopped DC motor also starts it.
// - Stopping a DC motor gates off both high and low outputs.
// - Start loads high startup duty and enables only high or low by direction.
// - After start, duty steps down on PWM period events to a lower requested duty; a higher one is loaded at the next event.
// - Full-step clockwise: 1+3, 1+4, 2+4, 2+3; reverse for counterclockwise.
// - Half-step clockwise eight states; reverse order for counterclockwise.
package mmd_pkg;

  localparam int SYS_CLK_NS = 4;

  // Servo timing
  localparam int SERVO_TICK_NS = 50000;
  localparam int SERVO_TICK_CYC = SERVO_TICK_NS / SYS_CLK_NS;
  localparam int FRAME_NS = 20000000;
  localparam int FRAME_TICKS = FRAME_NS / SERVO_TICK_NS;
  localparam int NEUTRAL_NS = 1500000;
  localparam int NEUTRAL_TICKS = NEUTRAL_NS / SERVO_TICK_NS;
  localparam int POS_LIMIT = 11;
  localparam int SPI_GUARD_TICKS = 4;
  localparam int SERVO_CH = 4;
  localparam int TICK_W = 9;
  localparam int POS_W = 5;

  // Stepper command and timing
  localparam logic [6:0] STEP_CMD_STOP = 7'h00;
  localparam logic [6:0] STEP_CMD_SINGLE = 7'h01;
  localparam logic [6:0] STEP_CMD_MAX = 7'h64;
  localparam int STEP_UNIT_NS = 100000;
  localparam int STEP_UNIT_CYC = STEP_UNIT_NS / SYS_CLK_NS;
  localparam logic [3:0] COIL_MASK = 4'h0;
  localparam logic [3:0] COIL_RESET = 4'h0;
  // Bit 0 is the first driver
  localparam logic [0:3][3:0] FULL_PAT = {4'h5, 4'h9, 4'ha, 4'h6};
  localparam logic [0:7][3:0] HALF_PAT = {4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};

  // DC motor PWM
  localparam int DC_CH = 2;
  localparam int PWM_PERIOD_NS = 50000;
  localparam logic [6:0] PWM_STEPS = 7'h64;
  localparam int PWM_SLOT_CYC = PWM_PERIOD_NS / SYS_CLK_NS / 100;
  localparam logic [6:0] STARTUP_DUTY = 7'h5a;

  typedef enum logic [2:0] {
    MMD_DC_IDLE = 3'b001,
    MMD_DC_RUN = 3'b010,
    MMD_DC_RESTART = 3'b100
  } mmd_dc_state_t;

endpackage

// ---- src/mmd_stepper.sv ----
/*
  One stepper channel: period timer, step index and coil pattern register.
  Assumes command strobes are one-cycle pulses synchronous to i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_stepper
  import mmd_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Control
  input wire logic [6:0] i_cmd,
  input wire logic i_cmd_wr,
  input wire logic i_dir_ccw,
  input wire logic i_half,
  // Coil drivers
  output logic [3:0] o_coil
);

  if (UNIT_CYC < 1) begin : g_chk
    $error("UNIT_CYC must be at least 1");
  end

  typedef struct packed {
    logic run;
    logic [31:0] cnt;
    logic [31:0] period;
    logic [2:0] idx;
    logic [3:0] coil;
  } mmd_step_st_t;

  mmd_step_st_t s;
  mmd_step_st_t next_s;
  logic adv;
  logic [6:0] cmd;

  function automatic logic [3:0] pattern(input logic ccw, input logic half, input logic [2:0] idx);
    if (half) begin
      pattern = ccw ? HALF_PAT[3'h7 - idx] : HALF_PAT[idx];
    end else begin
      pattern = ccw ? FULL_PAT[2'h3 - idx[1:0]] : FULL_PAT[idx[1:0]];
    end
  endfunction

  always_comb begin
    next_s = s;
    adv = 1'b0;
    cmd = (i_cmd > STEP_CMD_MAX) ? STEP_CMD_MAX : i_cmd;
    if (i_cmd_wr) begin
      if (cmd <= STEP_CMD_SINGLE) begin
        next_s.run = 1'b0;
        adv = (cmd == STEP_CMD_SINGLE);
      end else begin
        next_s.run = 1'b1;
        next_s.period = 32'(cmd) * 32'(UNIT_CYC);
        next_s.cnt = 32'h0;
      end
    end else if (s.run) begin
      if (s.cnt >= s.period - 32'h1) begin
        next_s.cnt = 32'h0;
        adv = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 32'h1;
      end
    end
    if (adv) begin
      next_s.idx = i_half ? s.idx + 3'h1 : {1'b0, s.idx[1:0] + 2'h1};
      next_s.coil = (s.coil & COIL_MASK) | pattern(i_dir_ccw, i_half, next_s.idx);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_coil = s.coil;

  AST_STEP_EXPIRY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s.run && !i_cmd_wr && s.cnt == s.period - 32'h1 |=> s.idx != $past(s.idx) && s.cnt == 32'h0)
    else $error("stepper expiry did not advance once");
  AST_STEP_STOP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cmd_wr && i_cmd <= STEP_CMD_SINGLE |=> !s.run ##1 $stable(s.idx))
    else $error("stepper timer still running after stop");

endmodule
`default_nettype wire

// ---- src/mmd_top.sv ----
/*
  Motor drive controller: four servo pulse trains with SPI pin sharing,
  unipolar and bipolar stepper channels, two DC motor PWM channels.
  Assumes inputs synchronous to i_sys_clk and strobes one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_top
  import mmd_pkg::*;
#(
  parameter int TICK_CYC = SERVO_TICK_CYC,
  parameter int STEP_CYC = STEP_UNIT_CYC,
  parameter int GUARD_TICKS = SPI_GUARD_TICKS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Servo control
  input wire logic [SERVO_CH-1:0] i_servo_en,
  input wire logic [SERVO_CH-1:0][POS_W-1:0] i_servo_pos,
  // SPI side of the shared pins
  input wire logic i_spi_req,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_grant,
  // Servo pins
  output logic [1:0] o_servo,
  output logic o_shared_servo_out_a,
  input wire logic i_shared_servo_out_b,
  output logic o_shared_servo_out_b,
  output logic o_shared_servo_out_b_oe,
  // Stepper control
  input wire logic [6:0] i_uni_cmd,
  input wire logic i_uni_cmd_wr,
  input wire logic i_uni_dir_ccw,
  input wire logic i_uni_half,
  input wire logic [6:0] i_bi_cmd,
  input wire logic i_bi_cmd_wr,
  input wire logic i_bi_dir_ccw,
  input wire logic i_bi_half,
  // Stepper drivers
  output logic [3:0] o_uni_coil,
  output logic [3:0] o_bi_coil,
  // DC motor control
  input wire logic [DC_CH-1:0] i_dc_start,
  input wire logic [DC_CH-1:0] i_dc_stop,
  input wire logic [DC_CH-1:0] i_dc_dir_ccw,
  input wire logic [DC_CH-1:0][6:0] i_dc_speed,
  input wire logic [DC_CH-1:0] i_dc_speed_wr,
  // DC motor drivers and status
  output logic [DC_CH-1:0] o_dc_hi,
  output logic [DC_CH-1:0] o_dc_lo,
  output logic [DC_CH-1:0] o_dc_running
);

  if (TICK_CYC < 2 || GUARD_TICKS < 1 || GUARD_TICKS >= FRAME_TICKS) begin : g_chk
    $error("unsupported TICK_CYC or GUARD_TICKS");
  end

  typedef struct packed {
    logic [15:0] div;
    logic tick;
    logic [TICK_W-1:0] tick_cnt;
    logic [SERVO_CH-1:0] pulse;
    logic grant;
    logic miso;
    logic pin_a;
    logic pin_b;
    logic pin_b_oe;
    logic [7:0] slot;
    logic [6:0] pwm_cnt;
    logic pwm_evt;
    mmd_dc_state_t [DC_CH-1:0] dc_st;
    logic [DC_CH-1:0][6:0] duty;
    logic [DC_CH-1:0][6:0] req;
    logic [DC_CH-1:0] dir;
    logic [DC_CH-1:0] gate_hi;
    logic [DC_CH-1:0] gate_lo;
    logic [DC_CH-1:0] hi;
    logic [DC_CH-1:0] lo;
  } mmd_st_t;

  mmd_st_t s;
  mmd_st_t next_s;
  logic [DC_CH-1:0] go;

  // Pulse length in ticks, position clamped to the legal range
  function automatic logic [TICK_W-1:0] pulse_len(input logic [POS_W-1:0] pos);
    logic signed [POS_W-1:0] p;
    p = signed'(pos);
    if (p > POS_W'(POS_LIMIT)) begin
      p = POS_W'(POS_LIMIT);
    end else if (p < -POS_W'(POS_LIMIT)) begin
      p = -POS_W'(POS_LIMIT);
    end
    pulse_len = TICK_W'(NEUTRAL_TICKS) + TICK_W'(p);
  endfunction

  always_comb begin
    next_s = s;
    go = '0;
    // Servo timebase and frame
    next_s.tick = 1'b0;
    if (s.div == 16'(TICK_CYC - 1)) begin
      next_s.div = 16'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 16'h1;
    end
    if (s.tick) begin
      if (s.tick_cnt == TICK_W'(FRAME_TICKS - 1)) begin
        next_s.tick_cnt = '0;
      end else begin
        next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
      end
      for (int i = 0; i < SERVO_CH; i++) begin
        next_s.pulse[i] = i_servo_en[i] && (next_s.tick_cnt < pulse_len(i_servo_pos[i]));
      end
    end
    // Pin sharing; select and clock of SPI are not touched here
    next_s.grant = i_spi_req && !next_s.pulse[2] && !next_s.pulse[3]
      && (next_s.tick_cnt < TICK_W'(FRAME_TICKS - GUARD_TICKS));
    next_s.pin_a = next_s.grant ? i_spi_mosi : next_s.pulse[2];
    next_s.pin_b = next_s.pulse[3];
    next_s.pin_b_oe = !next_s.grant;
    next_s.miso = next_s.grant ? i_shared_servo_out_b : 1'b0;
    // PWM period
    next_s.pwm_evt = 1'b0;
    if (s.slot == 8'(PWM_SLOT_CYC - 1)) begin
      next_s.slot = 8'h0;
      if (s.pwm_cnt == PWM_STEPS - 7'h1) begin
        next_s.pwm_cnt = 7'h0;
        next_s.pwm_evt = 1'b1;
      end else begin
        next_s.pwm_cnt = s.pwm_cnt + 7'h1;
      end
    end else begin
      next_s.slot = s.slot + 8'h1;
    end
    // DC motors, stop wins over start and speed
    for (int m = 0; m < DC_CH; m++) begin
      if (i_dc_speed_wr[m]) begin
        next_s.req[m] = (i_dc_speed[m] > PWM_STEPS) ? PWM_STEPS : i_dc_speed[m];
      end
      unique case (s.dc_st[m])
        MMD_DC_IDLE: begin
          go[m] = i_dc_start[m] || i_dc_speed_wr[m];
          next_s.dir[m] = i_dc_dir_ccw[m];
        end
        MMD_DC_RUN: begin
          go[m] = i_dc_start[m];
          if (i_dc_dir_ccw[m] != s.dir[m]) begin
            next_s.dir[m] = i_dc_dir_ccw[m];
            next_s.gate_hi[m] = 1'b0;
            next_s.gate_lo[m] = 1'b0;
            next_s.dc_st[m] = MMD_DC_RESTART;
            go[m] = 1'b0;
          end else if (s.pwm_evt && s.duty[m] > next_s.req[m]) begin
            next_s.duty[m] = s.duty[m] - 7'h1;
          end else if (s.pwm_evt && s.duty[m] < next_s.req[m]) begin
            next_s.duty[m] = next_s.req[m];
          end
        end
        MMD_DC_RESTART: begin
          go[m] = 1'b1;
        end
      endcase
      if (i_dc_stop[m]) begin
        go[m] = 1'b0;
        next_s.gate_hi[m] = 1'b0;
        next_s.gate_lo[m] = 1'b0;
        next_s.dc_st[m] = MMD_DC_IDLE;
      end else if (go[m]) begin
        next_s.duty[m] = STARTUP_DUTY;
        next_s.gate_hi[m] = !next_s.dir[m];
        next_s.gate_lo[m] = next_s.dir[m];
        next_s.dc_st[m] = MMD_DC_RUN;
      end
      next_s.hi[m] = next_s.gate_hi[m] && (next_s.pwm_cnt < next_s.duty[m]);
      next_s.lo[m] = next_s.gate_lo[m] && (next_s.pwm_cnt < next_s.duty[m]);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.pin_b_oe <= 1'b1;
      s.dc_st <= {DC_CH{MMD_DC_IDLE}};
    end else begin
      s <= next_s;
    end
  end

  assign o_servo = s.pulse[1:0];
  assign o_shared_servo_out_a = s.pin_a;
  assign o_shared_servo_out_b = s.pin_b;
  assign o_shared_servo_out_b_oe = s.pin_b_oe;
  assign o_spi_miso = s.miso;
  assign o_spi_grant = s.grant;
  assign o_dc_hi = s.hi;
  assign o_dc_lo = s.lo;
  always_comb begin
    for (int m = 0; m < DC_CH; m++) begin
      o_dc_running[m] = (s.dc_st[m] == MMD_DC_RUN);
    end
  end

  mmd_stepper #(.UNIT_CYC(STEP_CYC)) u_uni (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_cmd(i_uni_cmd),
    .i_cmd_wr(i_uni_cmd_wr),
    .i_dir_ccw(i_uni_dir_ccw),
    .i_half(i_uni_half),
    .o_coil(o_uni_coil)
  );

  mmd_stepper #(.UNIT_CYC(STEP_CYC)) u_bi (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_cmd(i_bi_cmd),
    .i_cmd_wr(i_bi_cmd_wr),
    .i_dir_ccw(i_bi_dir_ccw),
    .i_half(i_bi_half),
    .o_coil(o_bi_coil)
  );

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_TICK_SPACING: assert property (s.tick |=> !s.tick [*2])
    else $error("servo ticks too close");
  AST_FRAME_WRAP: assert property (s.tick && s.tick_cnt == TICK_W'(FRAME_TICKS - 1) |=> s.tick_cnt == '0)
    else $error("frame did not wrap at end");
  AST_PULSE_START: assert property (s.tick && s.tick_cnt == TICK_W'(FRAME_TICKS - 1) && i_servo_en[0]
    |=> s.pulse[0])
    else $error("servo pulse missing at frame start");
  AST_PULSE_LEN: assert property (s.pulse[0] |-> s.tick_cnt < TICK_W'(NEUTRAL_TICKS + POS_LIMIT))
    else $error("servo pulse wider than limit");
  AST_POS_CLAMP: assert property (pulse_len(i_servo_pos[1]) >= TICK_W'(NEUTRAL_TICKS - POS_LIMIT)
    && pulse_len(i_servo_pos[1]) <= TICK_W'(NEUTRAL_TICKS + POS_LIMIT))
    else $error("servo length outside range");
  AST_GRANT_SAFE: assert property (s.grant |-> !s.pulse[2] && !s.pulse[3] && s.pin_b_oe == 1'b0)
    else $error("shared pins granted during pulse");
  AST_DC_STOP: assert property (i_dc_stop[1] |=> !s.gate_hi[1] && !s.gate_lo[1] ##1 !o_dc_hi[1])
    else $error("DC motor not gated off after stop");
  AST_DC_START: assert property (i_dc_start[1] && !i_dc_stop[1] && s.dc_st[1] == MMD_DC_IDLE
    |=> s.duty[1] == STARTUP_DUTY && (s.gate_hi[1] ^ s.gate_lo[1]))
    else $error("DC start without startup duty or single side");
  AST_DC_RAMP: assert property (s.dc_st[0] == MMD_DC_RUN && s.pwm_evt && s.duty[0] > s.req[0]
    && !i_dc_stop[0] && !i_dc_start[0] && !i_dc_speed_wr[0] && i_dc_dir_ccw[0] == s.dir[0]
    |=> s.duty[0] == $past(s.duty[0]) - 7'h1)
    else $error("DC duty did not step down");
  AST_DC_DIR: assert property (s.dc_st[1] == MMD_DC_RUN && i_dc_dir_ccw[1] != s.dir[1] && !i_dc_stop[1]
    |=> s.dc_st[1] == MMD_DC_RESTART && !s.gate_hi[1] && !s.gate_lo[1]
    ##1 (s.dc_st[1] == MMD_DC_RUN || i_dc_stop[1] || $past(i_dc_stop[1])))
    else $error("DC direction change did not restart");
  CVR_SPI_GRANT: cover property (!s.grant ##1 s.grant);
  CVR_DC_RESTART: cover property (s.dc_st[1] == MMD_DC_RESTART ##1 s.dc_st[1] == MMD_DC_RUN);
  CVR_SERVO_FALL: cover property (s.pulse[0] ##1 !s.pulse[0]);

endmodule
`default_nettype wire

// ---- verification/mmd_drive_model.sv ----
/*
  Driver stage model: resolves shared pin b, flags bridge shorts.
  Assumes design outputs change on the rising edge of i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_drive_model (
  // Clock
  input wire logic i_sys_clk,
  // Driver inputs
  input wire logic [3:0] i_bi_coil,
  input wire logic [1:0] i_dc_hi,
  input wire logic [1:0] i_dc_lo,
  input wire logic i_pin_b,
  input wire logic i_pin_b_oe,
  // Resolved pin and fault
  output logic o_pin_b,
  output logic o_fault
);
  logic slave_bit = 1'h0;
  initial o_fault = 1'h0;
  // Slave data changes every cycle
  always @(posedge i_sys_clk) slave_bit <= ~slave_bit;
  assign o_pin_b = i_pin_b_oe ? i_pin_b : slave_bit;
  // Both legs of one bridge on is a short
  always @(posedge i_sys_clk) begin
    if (|(i_dc_hi & i_dc_lo)) o_fault <= 1'h1;
    if ((&i_bi_coil[1:0]) || (&i_bi_coil[3:2])) o_fault <= 1'h1;
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
/*
  Self-checking bench for the motor drive controller top.
  Assumes short tick and step parameters to keep the run brief.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mmd_pkg::*;
  localparam int TK = 5;
  localparam int SC = 3;
  localparam int GT = 4;
  localparam int FC = FRAME_TICKS * TK;
  localparam int PC = 101 * PWM_SLOT_CYC;
  logic i_sys_clk = 1'h0, i_rst = 1'h1;
  logic [3:0] servo_en = 4'h0;
  logic [3:0][4:0] servo_pos = '0;
  logic spi_req = 1'h0, spi_mosi = 1'h0;
  logic [6:0] uni_cmd = 7'h0, bi_cmd = 7'h0;
  logic uni_wr = 1'h0, bi_wr = 1'h0, uni_ccw = 1'h0, bi_ccw = 1'h0;
  logic [1:0] dc_start = 2'h0, dc_stop = 2'h0, dc_ccw = 2'h0, dc_wr = 2'h0;
  logic [1:0][6:0] dc_speed = '0;
  logic spi_miso, spi_grant, pin_a, pin_b_out, pin_b_oe, pin_b, fault;
  logic [1:0] servo, dc_hi, dc_lo, dc_run;
  logic [3:0] uni_coil, bi_coil;
  logic [10:0] mon;
  logic [3:0] fp[4] = '{4'h5, 4'h9, 4'ha, 4'h6};
  logic [3:0] hp[8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};
  int errors = 0, n_checks = 0, cyc = 0, uidx = 0, bidx = 0;
  assign mon = {dc_run, spi_grant, dc_lo, dc_hi, pin_b_out, pin_a, servo};
  mmd_top #(.TICK_CYC(TK), .STEP_CYC(SC), .GUARD_TICKS(GT)) mmd_top_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_servo_en(servo_en), .i_servo_pos(servo_pos),
    .i_spi_req(spi_req), .i_spi_mosi(spi_mosi), .o_spi_miso(spi_miso), .o_spi_grant(spi_grant),
    .o_servo(servo), .o_shared_servo_out_a(pin_a), .i_shared_servo_out_b(pin_b),
    .o_shared_servo_out_b(pin_b_out), .o_shared_servo_out_b_oe(pin_b_oe),
    .i_uni_cmd(uni_cmd), .i_uni_cmd_wr(uni_wr), .i_uni_dir_ccw(uni_ccw), .i_uni_half(1'h0),
    .i_bi_cmd(bi_cmd), .i_bi_cmd_wr(bi_wr), .i_bi_dir_ccw(bi_ccw), .i_bi_half(1'h1),
    .o_uni_coil(uni_coil), .o_bi_coil(bi_coil), .i_dc_start(dc_start), .i_dc_stop(dc_stop),
    .i_dc_dir_ccw(dc_ccw), .i_dc_speed(dc_speed), .i_dc_speed_wr(dc_wr),
    .o_dc_hi(dc_hi), .o_dc_lo(dc_lo), .o_dc_running(dc_run));
  mmd_drive_model mmd_drive_model_inst (.i_sys_clk(i_sys_clk), .i_bi_coil(bi_coil),
    .i_dc_hi(dc_hi), .i_dc_lo(dc_lo), .i_pin_b(pin_b_out), .i_pin_b_oe(pin_b_oe),
    .o_pin_b(pin_b), .o_fault(fault));
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 99000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (mon[k] !== v && n <= lim) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(mon[k], v);
  endtask
  task automatic t_reset();
    @(posedge i_sys_clk) i_rst <= 1'h1;
    repeat (10) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check({mon, uni_coil, bi_coil}, '0);
    check(pin_b_oe, 1'h1);
    @(posedge i_sys_clk) i_rst <= 1'h0;
  endtask
  task automatic t_servo(input logic [3:0][4:0] pos, input int w[4]);
    int n, hi[4];
    @(posedge i_sys_clk);
    servo_en <= 4'hf;
    servo_pos <= pos;
    wait_lvl(0, 1'h0, FC, n);
    wait_lvl(0, 1'h1, 2 * FC, n);
    check(mon[3:0], 4'hf);
    hi = '{0, 0, 0, 0};
    for (int c = 0; c < FC; c++) begin
      for (int k = 0; k < 4; k++) hi[k] += mon[k];
      @(negedge i_sys_clk);
    end
    for (int k = 0; k < 4; k++) check(hi[k], w[k] * TK);
    check(mon[0], 1'h1);
  endtask
  task automatic t_spi();
    int n;
    logic p;
    wait_lvl(2, 1'h1, FC, n);
    wait_lvl(3, 1'h0, 60 * TK, n);
    @(posedge i_sys_clk);
    spi_req <= 1'h1;
    spi_mosi <= 1'h1;
    repeat (3) @(negedge i_sys_clk);
    check({spi_grant, pin_b_oe, pin_a}, 3'h5);
    p = pin_b;
    @(negedge i_sys_clk);
    check(spi_miso, p);
    wait_lvl(8, 1'h0, FC, n);
    check(pin_b_oe, 1'h1);
    wait_lvl(2, 1'h1, FC, n);
    check(n >= (GT - 1) * TK && n <= GT * TK + 2, 1'h1);
    check(spi_grant, 1'h0);
    wait_lvl(3, 1'h0, 60 * TK, n);
    wait_lvl(8, 1'h1, 3, n);
    @(posedge i_sys_clk) spi_req <= 1'h0;
  endtask
  task automatic t_step_single(input logic bi, input logic ccw, input int steps);
    for (int s = 0; s < steps; s++) begin
      @(posedge i_sys_clk);
      if (bi) begin
        {bi_cmd, bi_wr, bi_ccw} <= {7'h1, 1'h1, ccw};
      end else begin
        {uni_cmd, uni_wr, uni_ccw} <= {7'h1, 1'h1, ccw};
      end
      @(posedge i_sys_clk);
      {bi_wr, uni_wr} <= 2'h0;
      @(negedge i_sys_clk);
      if (bi) begin
        bidx = (bidx + 1) % 8;
        check(bi_coil, hp[ccw ? 7 - bidx : bidx]);
      end else begin
        uidx = (uidx + 1) % 4;
        check(uni_coil, fp[ccw ? 3 - uidx : uidx]);
      end
    end
  endtask
  task automatic t_step_run();
    int n;
    logic [3:0] p;
    @(posedge i_sys_clk);
    {uni_cmd, uni_wr, uni_ccw} <= {7'h2, 1'h1, 1'h0};
    @(posedge i_sys_clk) uni_wr <= 1'h0;
    for (int s = 0; s < 3; s++) begin
      p = uni_coil;
      n = 0;
      do begin
        @(negedge i_sys_clk);
        n++;
      end while (uni_coil === p && n < 20);
      uidx = (uidx + 1) % 4;
      // First step counts from the cycle that took the command
      check(n, 2 * SC + (s == 0));
      check(uni_coil, fp[uidx]);
    end
    @(posedge i_sys_clk);
    {uni_cmd, uni_wr} <= {7'h0, 1'h1};
    @(posedge i_sys_clk) uni_wr <= 1'h0;
    p = uni_coil;
    repeat (30) @(negedge i_sys_clk);
    check(uni_coil, p);
  endtask
  task automatic t_dc();
    int n, bad, w[3];
    bad = 0;
    @(posedge i_sys_clk);
    dc_speed[0] <= 7'h58;
    dc_wr <= 2'h1;
    @(posedge i_sys_clk) dc_wr <= 2'h0;
    @(negedge i_sys_clk) check(dc_run, 2'h1);
    for (int p = 0; p < 3; p++) begin
      wait_lvl(4, 1'h0, PC, n);
      wait_lvl(4, 1'h1, PC, n);
      w[p] = 0;
      while (dc_hi[0] === 1'h1 && w[p] < PC) begin
        bad += dc_lo[0] | dc_hi[1] | dc_lo[1];
        @(negedge i_sys_clk);
        w[p]++;
      end
    end
    check(bad, 0);
    check(w[0] > 88 * PWM_SLOT_CYC, 1'h1);
    check(w[2], 88 * PWM_SLOT_CYC);
    @(posedge i_sys_clk);
    dc_ccw[1] <= 1'h1;
    dc_start <= 2'h2;
    @(posedge i_sys_clk) dc_start <= 2'h0;
    wait_lvl(7, 1'h1, PC, n);
    check(dc_hi[1], 1'h0);
    @(posedge i_sys_clk) dc_ccw[1] <= 1'h0;
    wait_lvl(10, 1'h0, 3, n);
    wait_lvl(10, 1'h1, 3, n);
    wait_lvl(5, 1'h1, PC, n);
    check(dc_lo[1], 1'h0);
    @(posedge i_sys_clk) dc_stop <= 2'h2;
    @(posedge i_sys_clk) dc_stop <= 2'h0;
    bad = 0;
    repeat (200) begin
      @(negedge i_sys_clk);
      bad += dc_hi[1] | dc_lo[1] | dc_run[1];
    end
    check(bad, 0);
  endtask
  initial begin
    t_reset();
    t_servo({5'h0f, 5'h10, 5'h15, 5'h00}, '{30, 19, 19, 41});
    t_servo({5'h00, 5'h1f, 5'h01, 5'h0b}, '{41, 31, 29, 30});
    t_spi();
    t_step_single(1'h0, 1'h0, 5);
    t_step_single(1'h0, 1'h1, 3);
    t_step_single(1'h1, 1'h0, 9);
    t_step_single(1'h1, 1'h1, 3);
    t_step_run();
    t_dc();
    check(fault, 1'h0);
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
